// [pkg/tccp_pkg.sv]
// Constants and types for the six-channel capture/compare/PWM timer
package tccp_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int unsigned NUM_CHAN = 6;
  localparam int unsigned CNT_W    = 16;
  localparam int unsigned BYTE_W   = 8;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] MOD_RST  = 16'hffff;
  localparam logic [15:0] CNT_RST  = 16'h0000;
  localparam logic [2:0]  PS_RST   = 3'h0;

  // ---------------------------------------------------------------
  // Edge/level select encodings (hi:lo)
  // ---------------------------------------------------------------
  localparam logic [1:0] ELS_NONE  = 2'h0;  // Capture: off, compare: flag only, pin released
  localparam logic [1:0] ELS_RISE  = 2'h1;  // Capture rising, compare toggle
  localparam logic [1:0] ELS_FALL  = 2'h2;  // Capture falling, compare clear
  localparam logic [1:0] ELS_ANY   = 2'h3;  // Capture both, compare set

  // ---------------------------------------------------------------
  // Channel mode type (from buffer_sel:unbuffered_mode_sel)
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    TCCP_CAPTURE  = 2'b00,
    TCCP_UNBUF    = 2'b01,
    TCCP_BUF      = 2'b10
  } tccp_mode_t;

  // Pin synchroniser gives two cycles; the latch stage adds a third to capture
  localparam int unsigned CAPT_LAT = 2;

endpackage : tccp_pkg

// [hdl/tccp_timer.sv]
// Six-channel capture/compare/PWM timer around a shared 16-bit counter
`timescale 1ns/10ps

// How it works
// - Two edge-level bits per channel pick rising, falling or either edge.
// - Each channel value is 16 bits, split into high and low bytes.
// - Active capture edge copies the counter into the channel value.
// - Capture happens on every selected edge regardless of the event flag.
// - Set event flag with its interrupt enable raises the interrupt request.
// - Captured value lands three clock cycles after the pin edge.
// - New capture overwrites the older value.
// - Reset leaves channel value registers untouched.
// - Compare match sets, clears or toggles the channel pin.
// - Compare match sets the channel event flag.
// - Unbuffered compare values take effect immediately on write.
// - Buffer select on channel 0 links channels 0 and 1 on pin 0.
// - Linked pair switches to most recently written set at overflow.
// - Linked even control governs pair; odd pin released to GPIO.
// - Buffer select on channel 2 links channels 2 and 3.
// - Buffer select on channel 4 links channels 4 and 5.
// - Toggle-at-wrap toggles the pin when the counter hits modulo.
// - Modulo 255 undivided gives a 256-clock PWM period.
// - Counter is 16-bit up, free running or bounded by modulo.
// - Mode 01 is unbuffered, 10 buffered; buffer bit has priority.
// - With clear on compare, no toggle-at-wrap gives 0% duty; full duty bit with toggle-at-wrap gives 100%.
module tccp_timer
  import tccp_pkg::*;
#(
  parameter int unsigned N = NUM_CHAN
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_stop,
  input  wire logic             i_cnt_clr,
  input  wire logic [2:0]       i_prescale,
  input  wire logic [15:0]      i_modulo,
  input  wire logic [N-1:0]     i_pin,
  input  wire logic [N-1:0]     i_unbuffered_mode_sel,
  input  wire logic [N-1:0]     i_buffer_sel,
  input  wire logic [N-1:0]     i_edge_level_sel_hi,
  input  wire logic [N-1:0]     i_edge_level_sel_lo,
  input  wire logic [N-1:0]     i_toggle_at_wrap,
  input  wire logic [N-1:0]     i_full_duty_sel,
  input  wire logic [N-1:0]     i_int_en,
  input  wire logic [N-1:0]     i_flag_clr,
  input  wire logic [N-1:0]     i_val_wr_hi,
  input  wire logic [N-1:0]     i_val_wr_lo,
  input  wire logic [7:0]       i_wdata,
  output logic      [15:0]      o_count,
  output logic      [N*16-1:0]  o_chan_value,
  output logic      [N-1:0]     o_chan_event_flag,
  output logic      [N-1:0]     o_pin,
  output logic      [N-1:0]     o_pin_oe_n,
  output logic      [N-1:0]     o_irq,
  output logic                  o_overflow,
  output logic      [2:0]       o_active_odd
);

  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  // Mode from the select bits, buffer bit wins
  function automatic tccp_mode_t mode_of(input logic b, input logic a);
    if (b) begin
      return TCCP_BUF;
    end else if (a) begin
      return TCCP_UNBUF;
    end
    return TCCP_CAPTURE;
  endfunction : mode_of

  // Edge qualifier for capture
  function automatic logic edge_hit(input logic [1:0] sel,
                                    input logic cur, input logic prv);
    case (sel)
      ELS_RISE: return cur & ~prv;
      ELS_FALL: return ~cur & prv;
      ELS_ANY:  return cur ^ prv;
      default:  return 1'b0;
    endcase
  endfunction : edge_hit

  // -------------------------------------------------------------
  // Prescaler and counter
  // -------------------------------------------------------------
  logic [6:0]  pre_q, pre_d;
  logic [15:0] cnt_q, cnt_d;
  logic        tick, wrap;

  // Divider tick: divide by 2**prescale
  always_comb begin
    pre_d = pre_q + 7'h01;
    tick  = 1'b0;
    if (i_prescale == PS_RST) begin
      tick = 1'b1;
    end else if (pre_q[i_prescale - 3'h1 +: 1] == 1'b1 &&
                 (pre_q & ((7'h01 << i_prescale) - 7'h01)) ==
                 ((7'h01 << i_prescale) - 7'h01)) begin
      tick = 1'b1;
    end
    if (i_stop) begin
      tick  = 1'b0;
      pre_d = pre_q;
    end
    if (i_cnt_clr) begin
      pre_d = 7'h00;
    end
  end

  // Up count, modulo plus one counts per period
  always_comb begin
    wrap  = tick && (cnt_q == i_modulo);
    cnt_d = cnt_q;
    if (i_cnt_clr) begin
      cnt_d = CNT_RST;
    end else if (wrap) begin
      cnt_d = CNT_RST;
    end else if (tick) begin
      cnt_d = cnt_q + 16'h0001;
    end
  end

  // Counter registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pre_q <= 7'h00;
      cnt_q <= CNT_RST;
    end else begin
      pre_q <= pre_d;
      cnt_q <= cnt_d;
    end
  end

  assign o_count    = cnt_q;
  assign o_overflow = wrap;

  // -------------------------------------------------------------
  // Pin synchronisers and edge history
  // -------------------------------------------------------------
  logic [N-1:0] sync1_q, sync2_q, prev_q;

  // Two-stage sync; prev only looks at the second stage
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q  <= '0;
    end else begin
      sync1_q <= i_pin;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // -------------------------------------------------------------
  // Channel logic
  // -------------------------------------------------------------
  logic [15:0]  val_q [N];
  logic [15:0]  val_d [N];
  logic [N-1:0] flag_q, flag_d, pin_q, pin_d, capt, match;
  logic [2:0]   act_q, act_d;    // Odd set active, per pair
  logic [2:0]   sel_q, sel_d;    // Odd set written last, per pair
  logic [N-1:0] oe_n;

  always_comb begin
    for (int i = 0; i < N; i++) begin
      val_d[i] = val_q[i];
    end
    flag_d = flag_q;
    pin_d  = pin_q;
    act_d  = act_q;
    sel_d  = sel_q;
    capt   = '0;
    match  = '0;
    oe_n   = '1;
    for (int p = 0; p < N / 2; p++) begin
      int e;
      int o;
      tccp_mode_t me;
      e  = 2 * p;
      o  = e + 1;
      me = mode_of(i_buffer_sel[e], i_unbuffered_mode_sel[e]);
      // Track last-written set of the pair
      if (i_val_wr_hi[o] || i_val_wr_lo[o]) begin
        sel_d[p] = 1'b1;
      end else if (i_val_wr_hi[e] || i_val_wr_lo[e]) begin
        sel_d[p] = 1'b0;
      end
      // Start on the even set when unlinked
      if (me != TCCP_BUF) begin
        act_d[p] = 1'b0;
        sel_d[p] = 1'b0;
      end else if (wrap) begin
        act_d[p] = sel_d[p];
      end
      for (int k = 0; k < 2; k++) begin
        int c;
        logic [1:0] els;
        tccp_mode_t m;
        logic linked_odd;
        logic [15:0] cmpv;
        c   = e + k;
        els = {i_edge_level_sel_hi[c], i_edge_level_sel_lo[c]};
        m   = mode_of(i_buffer_sel[c], i_unbuffered_mode_sel[c]);
        // Odd channel idle while linked, pin released
        linked_odd = (k == 1) && (me == TCCP_BUF);
        cmpv = (me == TCCP_BUF && k == 0 && act_q[p]) ? val_q[o] : val_q[c];
        // Software byte writes take effect at once
        if (i_val_wr_hi[c]) begin
          val_d[c][15:8] = i_wdata;
        end
        if (i_val_wr_lo[c]) begin
          val_d[c][7:0] = i_wdata;
        end
        if (linked_odd) begin
          oe_n[c] = 1'b1;
        end else if (m == TCCP_CAPTURE) begin
          capt[c] = edge_hit(els, sync2_q[c], prev_q[c]);
          if (capt[c]) begin
            val_d[c] = cnt_q;
          end
        end else begin
          oe_n[c]  = (els == ELS_NONE);
          match[c] = tick && (cnt_q == cmpv);
          // Toggle at wrap, forced high when full duty and toggle-at-wrap are both set
          if (wrap && i_toggle_at_wrap[c]) begin
            pin_d[c] = ~pin_q[c];
          end
          if (match[c]) begin
            case (els)
              ELS_RISE: pin_d[c] = ~pin_q[c];
              ELS_FALL: pin_d[c] = 1'b0;
              ELS_ANY:  pin_d[c] = 1'b1;
              default:  pin_d[c] = pin_q[c];
            endcase
          end
          if (i_full_duty_sel[c] && i_toggle_at_wrap[c]) begin
            pin_d[c] = 1'b1;
          end
        end
        // Event sets win over the clear
        if (capt[c] || match[c]) begin
          flag_d[c] = 1'b1;
        end else if (i_flag_clr[c]) begin
          flag_d[c] = 1'b0;
        end
      end
    end
  end

  // Control state
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      flag_q <= '0;
      pin_q  <= '0;
      act_q  <= 3'h0;
      sel_q  <= 3'h0;
    end else begin
      flag_q <= flag_d;
      pin_q  <= pin_d;
      act_q  <= act_d;
      sel_q  <= sel_d;
    end
  end

  always_ff @(posedge i_clk) begin
    for (int i = 0; i < N; i++) begin
      val_q[i] <= val_d[i];
    end
  end

  // Output packing
  always_comb begin
    for (int i = 0; i < N; i++) begin
      o_chan_value[i*16 +: 16] = val_q[i];
    end
  end

  assign o_irq             = flag_q & i_int_en;
  assign o_chan_event_flag = flag_q;
  assign o_pin             = pin_q;
  assign o_pin_oe_n        = oe_n;
  assign o_active_odd      = act_q;

  // -------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  chk_capt_latency: assert property (
    (!i_buffer_sel[0] && !i_unbuffered_mode_sel[0] &&
     i_edge_level_sel_lo[0] && !i_edge_level_sel_hi[0] &&
     $rose(sync2_q[0])) |=> val_q[0] == $past(cnt_q))
    else $error("capture value wrong");
  chk_flag_set: assert property (
    (capt[0] | match[0]) |=> flag_q[0])
    else $error("event flag not set");
  chk_irq_gate: assert property (
    o_irq[1] == (flag_q[1] & i_int_en[1]))
    else $error("irq mismatch");
  chk_wrap_zero: assert property (
    wrap && !i_cnt_clr |=> cnt_q == 16'h0000)
    else $error("counter not wrapped");
  chk_count_up: assert property (
    tick && !wrap && !i_cnt_clr |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("counter not counting");
  chk_clear_act: assert property (
    match[2] && i_edge_level_sel_hi[2] && !i_edge_level_sel_lo[2] &&
    !(i_full_duty_sel[2] && i_toggle_at_wrap[2]) |=> !pin_q[2])
    else $error("clear on compare failed");
  chk_odd_release: assert property (
    i_buffer_sel[0] |-> o_pin_oe_n[1] ##1 $stable(o_pin[1]))
    else $error("odd pin not released");
  chk_buf_switch: assert property (
    i_buffer_sel[0] && wrap && sel_q[0] && !i_val_wr_hi[0] &&
    !i_val_wr_lo[0] |=> act_q[0])
    else $error("pair did not switch");
  chk_full_duty: assert property (
    i_unbuffered_mode_sel[1] && !i_buffer_sel[1] && !i_buffer_sel[0] &&
    i_full_duty_sel[1] && i_toggle_at_wrap[1] |=> pin_q[1])
    else $error("full duty not high");

  cov_capture: cover property (capt[0]);
  cov_match:   cover property (match[2]);
  cov_switch:  cover property (act_q[0] && wrap);

endmodule : tccp_timer

// [bench/tccp_pin_src.sv]
// Pulse source standing at a timer capture pin
`timescale 1ns/10ps
module tccp_pin_src (
  input  wire logic       i_clk,
  input  wire logic       i_go,
  input  wire logic [7:0] i_width,
  output logic            o_pin
);
  logic [7:0] left_q;
  initial begin
    o_pin  = 1'b0;
    left_q = 8'h00;
  end
  // Pin stays high exactly i_width cycles after a go pulse
  always @(posedge i_clk) begin
    if (i_go) begin
      o_pin  <= 1'b1;
      left_q <= i_width - 8'h01;
    end else if (left_q != 8'h00) begin
      left_q <= left_q - 8'h01;
    end else begin
      o_pin <= 1'b0;
    end
  end
endmodule : tccp_pin_src

// [bench/tccp_timer_test.sv]
// Self-checking bench for the capture/compare/PWM timer
`timescale 1ns/10ps
module tccp_timer_test;
  import tccp_pkg::*;
  logic clk, rst, clr, go, p0;
  logic [15:0] modv, cnt, va, vb, v0;
  logic [5:0] ums, bsel, elh, ell, tov, fds, ien, fclr, whi, wlo;
  logic [5:0] flg, opin, oen, irq;
  logic [7:0] wd;
  logic [95:0] cval;
  logic [2:0] act;
  logic ovf;
  int mismatches, check_count, cyc, h, l;
  // ----------------------------------------------------------
  // Clock, partner and design
  // ----------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  tccp_pin_src SRC (.i_clk(clk), .i_go(go), .i_width(8'h0a), .o_pin(p0));
  tccp_timer DUT (.i_clk(clk), .i_rst(rst), .i_stop(1'b0),
    .i_cnt_clr(clr), .i_prescale(3'h0), .i_modulo(modv),
    .i_pin({5'h00, p0}), .i_unbuffered_mode_sel(ums),
    .i_buffer_sel(bsel), .i_edge_level_sel_hi(elh),
    .i_edge_level_sel_lo(ell), .i_toggle_at_wrap(tov),
    .i_full_duty_sel(fds), .i_int_en(ien), .i_flag_clr(fclr),
    .i_val_wr_hi(whi), .i_val_wr_lo(wlo), .i_wdata(wd),
    .o_count(cnt), .o_chan_value(cval), .o_chan_event_flag(flg),
    .o_pin(opin), .o_pin_oe_n(oen), .o_irq(irq),
    .o_overflow(ovf), .o_active_odd(act));
  // ----------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // Byte pair write, high byte first
  task automatic wr(input int c, input logic [15:0] v);
    @(posedge clk);
    whi[c] <= 1'b1;
    wd     <= v[15:8];
    @(posedge clk);
    whi[c] <= 1'b0;
    wlo[c] <= 1'b1;
    wd     <= v[7:0];
    @(posedge clk);
    wlo[c] <= 1'b0;
  endtask : wr
  // High and low time of one output pulse, in cycles
  task automatic hi_lo(input int p, output int hc, output int lc);
    hc = 0;
    lc = 0;
    for (int i = 0; i < 400 && opin[p] !== 1'b0; i++) @(posedge clk);
    for (int i = 0; i < 400 && opin[p] !== 1'b1; i++) @(posedge clk);
    while (opin[p] === 1'b1 && hc < 400) begin
      @(posedge clk);
      hc++;
    end
    while (opin[p] === 1'b0 && lc < 400) begin
      @(posedge clk);
      lc++;
    end
  endtask : hi_lo
  // Pulse the capture pin and sample the value mid and late
  task automatic pulse;
    v0 = cval[15:0];
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    tick(7);
    va = cval[15:0];
    tick(8);
    vb = cval[15:0];
  endtask : pulse
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    {rst, clr, go} = 3'b100;
    modv = 16'hffff;
    {ums, bsel, elh, ell, tov, fds, ien, fclr, whi, wlo} = '0;
    wd = 8'h00;
    tick(2);
    rst <= 1'b0;
    wr(5, 16'h1234);
    rst <= 1'b1;
    tick(2);
    #1 chk(cval[95:80], 16'h1234);
    chk(cnt, 16'h0000);
    @(posedge clk);
    rst <= 1'b0;
    // Either-edge capture: overwrite spaced by the pulse width
    elh[0] <= 1'b1;
    ell[0] <= 1'b1;
    ien[0] <= 1'b1;
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    tick(2);
    #1 chk(flg[0], 1'b0);
    tick(1);
    #1 chk(flg[0], 1'b1);
    chk(irq[0], 1'b1);
    tick(4);
    va = cval[15:0];
    tick(8);
    chk(cval[15:0] - va, 16'h000a);
    @(posedge clk);
    fclr[0] <= 1'b1;
    @(posedge clk);
    fclr[0] <= 1'b0;
    tick(1);
    #1 chk(irq[0], 1'b0);
    // Rising only, then falling only
    for (int m = 1; m < 3; m++) begin
      @(posedge clk);
      {elh[0], ell[0]} <= m[1:0];
      pulse();
      chk(va == v0, m == 2);
      chk(vb == va, m == 1);
    end
    // Unbuffered PWM on channel 1, clear on compare; restart the count
    modv   <= 16'h000f;
    clr    <= 1'b1;
    ums[1] <= 1'b1;
    elh[1] <= 1'b1;
    tov[1] <= 1'b1;
    @(posedge clk);
    clr    <= 1'b0;
    wr(1, 16'h0005);
    hi_lo(1, h, l);
    chk(16'(h), 16'h0006);
    chk(16'(h + l), 16'h0010);
    chk(oen[1], 1'b0);
    chk(flg[1], 1'b1);
    // Larger value written from the overflow point
    for (int i = 0; i < 40 && ovf !== 1'b1; i++) @(posedge clk);
    chk(ovf, 1'b1);
    chk(cnt, 16'h000f);
    wr(1, 16'h0009);
    hi_lo(1, h, l);
    chk(16'(h), 16'h000a);
    // Smaller value written just after the compare point
    for (int i = 0; i < 40 && opin[1] !== 1'b0; i++) @(posedge clk);
    wr(1, 16'h0003);
    hi_lo(1, h, l);
    chk(16'(h), 16'h0004);
    // No wrap toggle gives 0%, full duty gives 100%
    for (int k = 0; k < 2; k++) begin
      tov[1] <= k[0];
      fds[1] <= k[0];
      tick(20);
      for (int i = 0; i < 20; i++) begin
        @(posedge clk);
        chk(opin[1], k[0]);
      end
    end
    fds[1] <= 1'b0;
    // Buffered pairs; both mode bits set, buffer wins
    for (int p = 0; p < 3; p++) begin
      ums[2*p] <= 1'b1;
      bsel[2*p] <= 1'b1;
      {elh[2*p], ell[2*p], tov[2*p]} <= 3'b101;
      wr(2*p, 16'h0003);
      wr(2*p + 1, 16'h0007);
      hi_lo(2*p, h, l);
      chk(act[p], 1'b1);
      chk(16'(h), 16'h0008);
      chk(oen[2*p + 1], 1'b1);
      wr(2*p, 16'h0003);
      hi_lo(2*p, h, l);
      chk(act[p], 1'b0);
      chk(16'(h), 16'h0004);
    end
    tally_and_finish();
  end
endmodule : tccp_timer_test
